// ==== verilog/isac_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "isac_consts.svh"
module isac_slave
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Register port
   input wire isac_pkg::isac_bus_s bus,
   output logic [7:0] rdata,
   // Bus pins, open drain
   input wire logic scl_in,
   input wire logic sda_in,
   output var isac_pkg::isac_pin_s scl_pin,
   output var isac_pkg::isac_pin_s sda_pin,
   // Slave status
   output logic addressed,
   output logic dir_read
);
   import isac_pkg::*;

   function automatic logic isac_in_range(input logic [6:0] a, input logic [6:0] lo, input logic [6:0] hi);
      isac_in_range = (a > lo) && (a <= hi);
   endfunction

   isac_ctrl_s ctrl_r;
   logic [7:0] prim_r;
   logic [7:0] range_r;
   logic [7:0] baud_r;
   logic seen_r;
   logic gc_hit_r;
   logic range_hit_r;
   isac_state_e state_r;
   isac_state_e state_nxt;
   logic [7:0] shift_r;
   logic [3:0] bitcnt_r;
   logic scl_q;
   logic sda_q;
   logic pend_r;
   logic ack_r;
   logic tenbit_ok_r;
   logic tick;

   // Register decode
   wire wr_ctrl = bus.wr && (bus.addr == `ISAC_OFS_CTRL);
   wire wr_prim = bus.wr && (bus.addr == `ISAC_OFS_PRIM);
   wire wr_range = bus.wr && (bus.addr == `ISAC_OFS_RANGE);
   wire wr_baud = bus.wr && (bus.addr == `ISAC_OFS_BAUD);
   wire wr_stat = bus.wr && (bus.addr == `ISAC_OFS_STAT);
   wire [7:0] stat_w = {3'b000, seen_r, range_hit_r, gc_hit_r, dir_read, addressed};
   wire [7:0] rd_mux =
      (bus.addr == `ISAC_OFS_CTRL) ? ctrl_r :
      (bus.addr == `ISAC_OFS_PRIM) ? prim_r :
      (bus.addr == `ISAC_OFS_RANGE) ? range_r :
      (bus.addr == `ISAC_OFS_BAUD) ? baud_r :
      (bus.addr == `ISAC_OFS_STAT) ? stat_w : 8'h00;

   // Line events; pins are already synchronous to mclk
   wire scl_rise = scl_in && !scl_q;
   wire scl_fall = !scl_in && scl_q;
   wire start_det = scl_in && scl_q && sda_q && !sda_in;
   wire stop_det = scl_in && scl_q && !sda_q && sda_in;
   wire active = (state_r != ISAC_IDLE) && (state_r != ISAC_SKIP);

   // Byte just completed on this rising edge
   wire byte_done = scl_rise && active && (bitcnt_r == 4'h7);
   wire [7:0] byte_w = {shift_r[6:0], sda_in};
   wire [6:0] a7 = byte_w[7:1];
   wire rw_bit = byte_w[0];

   wire hit_range = ctrl_r.range_match_enable && isac_in_range(a7, prim_r[6:0], range_r[6:0]);
   // primary match alone when range is off
   wire hit_prim = (a7 == prim_r[6:0]);
   wire hit_gc = ctrl_r.gcen && (byte_w == `ISAC_GC_BYTE);
   // upper bits of the long address
   wire hit_tag = (byte_w[7:3] == `ISAC_TENBIT_TAG) && (byte_w[2:1] == ctrl_r.hi[2:1]);
   wire hit_low = (byte_w == {ctrl_r.hi[0], prim_r[6:0]});

   // address width selects the match path
   wire hit7 = !ctrl_r.ext && (hit_prim || hit_range);
   // upper bits only count in 10-bit mode
   wire hit10_w = ctrl_r.ext && hit_tag && !rw_bit;
   wire hit10_r = ctrl_r.ext && hit_tag && rw_bit && tenbit_ok_r;

   // Next state once an address or data byte is complete
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ISAC_ADDR1:
         begin
            if (hit_gc || hit7 || hit10_r)
               state_nxt = ISAC_DATA;
            else if (hit10_w)
               state_nxt = ISAC_ADDR2;
            else
               state_nxt = ISAC_SKIP;
         end
         ISAC_ADDR2:
         begin
            if (hit_low)
               state_nxt = ISAC_DATA;
            else
               state_nxt = ISAC_SKIP;
         end
         ISAC_DATA:
            state_nxt = ISAC_DATA;
         ISAC_IDLE:
            state_nxt = ISAC_IDLE;
         ISAC_SKIP:
            state_nxt = ISAC_SKIP;
         default:
            state_nxt = ISAC_IDLE;
      endcase
   end

   // Acknowledge decision for the byte in flight
   wire ack_nxt = (state_r == ISAC_DATA) ? !dir_read : (state_nxt != ISAC_SKIP);
   wire match_now = byte_done && (state_nxt == ISAC_DATA) && (state_r != ISAC_DATA);
   wire gc_now = match_now && (state_r == ISAC_ADDR1) && hit_gc;
   wire range_now = match_now && (state_r == ISAC_ADDR1) && hit_range && !hit_prim && !hit_gc;

   // Transfer events, named so the clocked blocks stay short
   wire bit_edge = scl_rise && active;
   wire shift_en = bit_edge && (bitcnt_r < `ISAC_ACK_SLOT);
   wire release_go = pend_r && tick;
   wire byte_turn = release_go && (bitcnt_r == `ISAC_AFTER_ACK);
   wire dir_nxt = (state_r == ISAC_ADDR1) && rw_bit;
   wire pair_done = byte_done && (state_r == ISAC_ADDR2) && hit_low;
   wire ack_drive = (bitcnt_r == `ISAC_ACK_SLOT) && ack_r;
   wire stat_clear = wr_stat && bus.wdata[`ISAC_STAT_SEEN];

   // full-speed slave timing bypasses the divider
   // otherwise slave timing follows the divider
   isac_rate_div u_rate
   (
      .mclk(mclk),
      .rst_n(rst_n),
      .bypass(ctrl_r.rind),
      .div(baud_r),
      .tick(tick)
   );

   // Register file
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_r <= `ISAC_CTRL_RST;
         prim_r <= `ISAC_PRIM_RST;
         range_r <= `ISAC_RANGE_RST;
         baud_r <= `ISAC_BAUD_RST;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_r <= bus.wdata & `ISAC_CTRL_WMASK;
         if (wr_prim)
            prim_r <= bus.wdata;
         if (wr_range)
            range_r <= bus.wdata;
         if (wr_baud)
            baud_r <= bus.wdata;
      end
   end

   // Read data stand for as many cycles as bus.rd is held, zero otherwise
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         rdata <= 8'h00;
      else
         rdata <= bus.rd ? rd_mux : 8'h00;
   end

   // Sticky match flag: a new match wins over a clear in the same cycle
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         seen_r <= 1'b0;
      else if (match_now)
         seen_r <= 1'b1;
      else if (stat_clear)
         seen_r <= 1'b0;
   end

   // Line history for edge detection
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end

   // Shift register takes one bit per rising SCL until the ack slot
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         shift_r <= 8'h00;
      else if (shift_en)
         shift_r <= byte_w;
   end

   // Match kind stays readable after STOP until the next match
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gc_hit_r <= 1'b0;
         range_hit_r <= 1'b0;
      end
      else if (match_now)
      begin
         gc_hit_r <= gc_now;
         range_hit_r <= range_now;
      end
   end

   // Long-address pairing survives a repeated START, only STOP ends it
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         tenbit_ok_r <= 1'b0;
      else if (stop_det)
         tenbit_ok_r <= 1'b0;
      else if (pair_done)
         tenbit_ok_r <= 1'b1;
   end

   // Transfer state, bit count and addressed status
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= ISAC_IDLE;
         bitcnt_r <= 4'h0;
         ack_r <= 1'b0;
         addressed <= 1'b0;
         dir_read <= 1'b0;
      end
      else if (stop_det)
      begin
         state_r <= ISAC_IDLE;
         bitcnt_r <= 4'h0;
         ack_r <= 1'b0;
         addressed <= 1'b0;
         dir_read <= 1'b0;
      end
      else if (start_det)
      begin
         // Repeated start keeps the 10-bit pairing for a read turn-around
         state_r <= ISAC_ADDR1;
         bitcnt_r <= 4'h0;
         ack_r <= 1'b0;
         addressed <= 1'b0;
         dir_read <= 1'b0;
      end
      else if (bit_edge)
      begin
         bitcnt_r <= bitcnt_r + 4'h1;
         if (byte_done)
         begin
            ack_r <= ack_nxt;
            state_r <= state_nxt;
            if (match_now)
            begin
               addressed <= 1'b1;
               dir_read <= dir_nxt;
            end
         end
      end
      else if (byte_turn)
      begin
         bitcnt_r <= 4'h0;
         ack_r <= 1'b0;
      end
   end

   // Clock stretch and acknowledge drive, paced by the slave tick
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pend_r <= 1'b0;
         scl_pin <= 2'b00;
         sda_pin <= 2'b00;
      end
      else if (start_det || stop_det)
      begin
         pend_r <= 1'b0;
         scl_pin.oe <= 1'b0;
         sda_pin.oe <= 1'b0;
      end
      else if (scl_fall && active)
      begin
         // hold SCL low until slave logic catches up
         pend_r <= 1'b1;
         scl_pin.oe <= 1'b1;
      end
      else if (release_go)
      begin
         // release paced by the divider when not independent
         pend_r <= 1'b0;
         scl_pin.oe <= 1'b0;
         sda_pin.oe <= ack_drive;
      end
      else if (!active)
      begin
         scl_pin.oe <= 1'b0;
         sda_pin.oe <= 1'b0;
      end
   end
endmodule // isac_slave
`default_nettype wire

// ==== verilog/isac_consts.svh ====
`ifndef ISAC_CONSTS_SVH
`define ISAC_CONSTS_SVH
// Register offsets
`define ISAC_OFS_CTRL 4'h5
`define ISAC_OFS_PRIM 4'h8
`define ISAC_OFS_RANGE 4'h9
`define ISAC_OFS_BAUD 4'hA
`define ISAC_OFS_STAT 4'hB
// Control field positions
`define ISAC_BIT_GCEN 7
`define ISAC_BIT_EXT 6
`define ISAC_BIT_RSV 5
`define ISAC_BIT_RIND 4
`define ISAC_BIT_RANGE_MATCH_ENABLE 3
`define ISAC_CTRL_WMASK 8'hDF
// Status field positions
`define ISAC_STAT_ADDRESSED 0
`define ISAC_STAT_RW 1
`define ISAC_STAT_GC 2
`define ISAC_STAT_RANGE 3
`define ISAC_STAT_SEEN 4
// Reset values
`define ISAC_CTRL_RST 8'h00
`define ISAC_PRIM_RST 8'h00
`define ISAC_RANGE_RST 8'h00
`define ISAC_BAUD_RST 8'h0F
// Protocol constants
`define ISAC_TENBIT_TAG 5'h1E
`define ISAC_GC_BYTE 8'h00
`define ISAC_ACK_SLOT 4'h8
`define ISAC_AFTER_ACK 4'h9
`endif

// ==== verilog/isac_pkg.sv ====
`default_nettype none
package isac_pkg;
   typedef enum logic [2:0] {
      ISAC_IDLE = 3'b000,
      ISAC_ADDR1 = 3'b001,
      ISAC_ADDR2 = 3'b010,
      ISAC_DATA = 3'b011,
      ISAC_SKIP = 3'b100
   } isac_state_e;

   typedef struct packed {
      logic gcen;
      logic ext;
      logic rsv;
      logic rind;
      logic range_match_enable;
      logic [2:0] hi;
   } isac_ctrl_s;

   typedef struct packed {
      logic out;
      logic oe;
   } isac_pin_s;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } isac_bus_s;
endpackage
`default_nettype wire

// ==== verilog/isac_rate_div.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "isac_consts.svh"
module isac_rate_div
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Rate selection
   input wire logic bypass,
   input wire logic [7:0] div,
   // Slave timing enable
   output logic tick
);
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic wrap;

   assign wrap = (cnt_r >= div);
   assign cnt_nxt = (wrap || bypass) ? 8'h00 : cnt_r + 8'h01;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_r <= 8'h00;
         tick <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         // Bypass gives a tick every cycle, the fastest slave rate
         tick <= bypass | wrap;
      end
   end
endmodule // isac_rate_div
`default_nettype wire

// ==== sim/isac_props.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "isac_consts.svh"
module isac_props
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Register port
   input wire isac_pkg::isac_bus_s bus,
   input wire logic [7:0] rdata,
   // Bus lines
   input wire logic scl_in,
   input wire logic sda_in,
   input wire isac_pkg::isac_pin_s scl_pin,
   input wire isac_pkg::isac_pin_s sda_pin,
   // Status
   input wire logic addressed,
   input wire logic dir_read
);
   import isac_pkg::*;
   logic [7:0] ctrl_r;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Shadow of the control register, so rate checks know the mode
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         ctrl_r <= `ISAC_CTRL_RST;
      else if (bus.wr && bus.addr == `ISAC_OFS_CTRL)
         ctrl_r <= bus.wdata & `ISAC_CTRL_WMASK;
   end
   sequence s_ctrl_rd;
      $past(bus.rd && bus.addr == `ISAC_OFS_CTRL);
   endsequence
   sequence s_stop;
      scl_in && $past(scl_in) && $rose(sda_in);
   endsequence
   sequence s_stretch;
      $rose(scl_pin.oe);
   endsequence
   AST_RDATA_IDLE: assert property (!$past(bus.rd) |-> rdata == 8'h00)
      else $error("rdata not zero");
   AST_CTRL_READ: assert property (s_ctrl_rd |-> rdata == ctrl_r)
      else $error("control readback wrong");
   AST_PIN_LOW: assert property (!scl_pin.out && !sda_pin.out)
      else $error("pin drives high");
   AST_FAST_RATE: assert property (s_stretch and ctrl_r[4] |-> ##[1:3] !scl_pin.oe)
      else $error("stretch too long");
   AST_BAUD_RATE: assert property (s_stretch and !ctrl_r[4] |-> ##[1:20] !scl_pin.oe)
      else $error("stretch beyond baud");
   AST_STRETCH_LOW: assert property (s_stretch |-> !scl_in)
      else $error("stretch with scl high");
   AST_STOP_CLEARS: assert property (s_stop |-> ##[1:4] !addressed)
      else $error("addressed after stop");
   AST_SDA_STEADY: assert property (scl_in && $past(scl_in) |-> $stable(sda_pin.oe))
      else $error("sda moved while scl high");
endmodule // isac_props
`default_nettype wire

// ==== sim/isac_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module isac_master
(
   // Clock
   input wire logic mclk,
   // Resolved lines
   input wire logic scl_in,
   input wire logic sda_in,
   // Pull-downs and hang flag
   output logic scl_oe,
   output logic sda_oe,
   output logic hung
);
   initial
   begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
      hung = 1'b0;
   end
   task automatic hold();
      repeat (20) @(posedge mclk);
   endtask
   // Slave may stretch, so follow the wire, not our own drive
   task automatic rise();
      scl_oe <= 1'b0;
      for (int n = 0; n < 99 && !scl_in; n++)
         @(posedge mclk);
      if (!scl_in)
         hung = 1'b1;
   endtask
   task automatic start();
      hold();
      rise();
      hold();
      sda_oe <= 1'b1;
      hold();
      scl_oe <= 1'b1;
   endtask
   task automatic stop();
      @(posedge mclk);
      sda_oe <= 1'b1;
      hold();
      rise();
      hold();
      sda_oe <= 1'b0;
      hold();
   endtask
   // MSB first, direction last, then ack slot
   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 8; i >= 0; i--)
      begin
         @(posedge mclk);
         sda_oe <= (i > 0) ? ~b[i-1] : 1'b0;
         hold();
         rise();
         ack = ~sda_in;
         hold();
         scl_oe <= 1'b1;
      end
   endtask
endmodule // isac_master
`default_nettype wire

// ==== sim/isac_slave_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "isac_consts.svh"
module isac_slave_bench;
   import isac_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   isac_bus_s bus = '0;
   logic [7:0] rdata;
   isac_pin_s scl_pin;
   isac_pin_s sda_pin;
   logic addressed;
   logic dir_read;
   logic m_scl;
   logic m_sda;
   logic hung;
   int num_errors = 0;
   int compares = 0;
   // Open-drain lines with pull-ups
   wire logic scl_w = ~(m_scl | scl_pin.oe);
   wire logic sda_w = ~(m_sda | sda_pin.oe);
   always #2 mclk = ~mclk;
   isac_slave uut (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .scl_in(scl_w), .sda_in(sda_w),
      .scl_pin(scl_pin), .sda_pin(sda_pin), .addressed(addressed), .dir_read(dir_read));
   isac_master master (.mclk(mclk), .scl_in(scl_w), .sda_in(sda_w), .scl_oe(m_scl), .sda_oe(m_sda), .hung(hung));
   task automatic tally_and_finish();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge mclk);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge mclk);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge mclk);
      bus.rd <= 1'b0;
      #1;
      chk("rdata", exp, rdata);
   endtask
   // One framed transfer; the last ack decides the match
   task automatic call(input logic [7:0] b1, input logic [7:0] b2, input logic two, input logic exp);
      logic a;
      master.start();
      master.send(b1, a);
      if (two)
         master.send(b2, a);
      chk("ack", {7'h0, exp}, {7'h0, a});
      chk("addressed", {7'h0, exp}, {7'h0, addressed});
      if (exp)
         chk("dir_read", {7'h0, b1[0]}, {7'h0, dir_read});
      master.stop();
      chk("addressed", 8'h00, {7'h0, addressed});
      if (hung)
      begin
         num_errors++;
         tally_and_finish();
      end
   endtask
   task automatic t_regs();
      rd(`ISAC_OFS_CTRL, 8'h00);
      rd(4'h3, 8'h00);
      wr(`ISAC_OFS_CTRL, 8'hFF);
      rd(`ISAC_OFS_CTRL, 8'hDF);
   endtask
   task automatic t_seven();
      wr(`ISAC_OFS_CTRL, 8'h00);
      wr(`ISAC_OFS_PRIM, 8'h2A);
      call(8'h54, 8'h00, 1'b0, 1'b1);
      rd(`ISAC_OFS_STAT, 8'h10);
      wr(`ISAC_OFS_STAT, 8'h10);
      rd(`ISAC_OFS_STAT, 8'h00);
      call(8'h56, 8'h00, 1'b0, 1'b0);
      call(8'h55, 8'h00, 1'b0, 1'b1);
      call(8'h00, 8'h00, 1'b0, 1'b0);
      wr(`ISAC_OFS_CTRL, 8'h87);
      call(8'h54, 8'h00, 1'b0, 1'b1);
      call(8'h00, 8'h00, 1'b0, 1'b1);
      rd(`ISAC_OFS_STAT, 8'h14);
   endtask
   task automatic t_range();
      wr(`ISAC_OFS_PRIM, 8'h10);
      wr(`ISAC_OFS_RANGE, 8'h14);
      wr(`ISAC_OFS_CTRL, 8'h00);
      call(8'h24, 8'h00, 1'b0, 1'b0);
      wr(`ISAC_OFS_CTRL, 8'h08);
      call(8'h22, 8'h00, 1'b0, 1'b1);
      rd(`ISAC_OFS_STAT, 8'h18);
      call(8'h28, 8'h00, 1'b0, 1'b1);
      call(8'h2A, 8'h00, 1'b0, 1'b0);
      wr(`ISAC_OFS_CTRL, 8'h18);
      call(8'h26, 8'h00, 1'b0, 1'b1);
   endtask
   task automatic t_ten();
      wr(`ISAC_OFS_PRIM, 8'h2A);
      wr(`ISAC_OFS_CTRL, 8'h45);
      call(8'hF4, 8'hAA, 1'b1, 1'b1);
      call(8'h54, 8'h00, 1'b0, 1'b0);
      wr(`ISAC_OFS_CTRL, 8'h44);
      call(8'hF4, 8'hAA, 1'b1, 1'b0);
   endtask
   initial
   begin
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      t_regs();
      t_seven();
      t_range();
      t_ten();
      tally_and_finish();
   end
endmodule // isac_slave_bench
bind isac_slave isac_props u_props (.mclk, .rst_n, .bus, .rdata, .scl_in, .sda_in, .scl_pin, .sda_pin,
   .addressed, .dir_read);
`default_nettype wire
